// *** core/cts_params.svh ***
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
// Supervisor register offsets (byte addresses)
`define CTS_REG_CTRL 12'h000
`define CTS_REG_MODE 12'h004
`define CTS_REG_WAIT 12'h008
`define CTS_REG_SETTLE 12'h00c
`define CTS_REG_MOFF 12'h010
`define CTS_REG_COFF 12'h014
`define CTS_REG_SPEED 12'h018
`define CTS_REG_STATUS 12'h01c
// Control register fields
`define CTS_CTRL_RUN_BIT 0
// Status fields
`define CTS_STAT_BUSY_BIT 8
// Reset values
`define CTS_MODE_RESET 2'h0
`define CTS_WAIT_RESET 16'h0002
`define CTS_SETTLE_RESET 32'h000f4240
// Chop mode codes
`define CTS_MODE_SINGLE 2'h0
`define CTS_MODE_TWO 2'h1
`define CTS_MODE_FOUR 2'h2
`endif

// *** core/cts_pkg.sv ***
package cts_pkg;
	typedef enum logic [4:0] {
		CTS_IDLE = 5'b00001,
		CTS_MOVING = 5'b00010,
		CTS_FROZEN = 5'b00100,
		CTS_AWAY = 5'b01000,
		CTS_SEND = 5'b10000
	} cts_state_type;
	// Message to the tip-tilt drive board
	typedef struct packed {
		logic away;
		logic [31:0] mirror_offset;
		logic [31:0] centroid_offset;
		logic [15:0] shaper_speed;
	} cts_drive_msg_type;
	// Flags inside the real-time packets to the slope unit
	typedef struct packed {
		logic tt_freeze;
		logic tt_unfreeze;
		logic dm_loop_enable;
	} cts_rt_flags_type;
endpackage

// *** core/cts_sequencer.sv ***
`include "cts_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cts_sequencer
	import cts_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Frame tick from the slope unit (pin)
	input wire logic frame_tick_in,
	// Drive board
	output cts_drive_msg_type drive_msg_out,
	output logic drive_msg_valid_out,
	// Slope unit real-time flags
	output cts_rt_flags_type rt_flags_out,
	output logic [1:0] chop_mode_out
);
	// Register map needs five address bits
	if (ADDR_W < 5) begin : g_addr_check
		$error("ADDR_W too small for register map");
	end

	cts_state_type state;
	logic run_enable;
	logic [1:0] chop_mode;
	logic [15:0] resume_wait_frames;
	logic [31:0] settle_cycles;
	logic [31:0] mirror_off;
	logic [31:0] centroid_off;
	logic [15:0] shaper_speed;
	logic target_away;
	logic [31:0] settle_cnt;
	logic [15:0] frame_cnt;
	logic settled;
	logic frame_s1;
	logic frame_s2;
	logic frame_s3;
	logic frame_pulse;
	logic wr_en;
	logic rd_en;
	logic wr_hit;
	logic [31:0] next_rdata;
	logic addr_ok;

	// Two-flop synchroniser for the asynchronous frame pin
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_s1 <= 1'b0;
			frame_s2 <= 1'b0;
		end else begin
			frame_s1 <= frame_tick_in;
			frame_s2 <= frame_s1;
		end
	end

	// Edge detect; resets to the idle pin level so no false frame
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_s3 <= 1'b0;
		end else begin
			frame_s3 <= frame_s2;
		end
	end
	assign frame_pulse = frame_s2 & ~frame_s3;

	// Reads sample in setup, writes land at the access edge
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign rd_en = psel_in & ~penable_in & ~pwrite_in;

	always_comb begin
		addr_ok = 1'b1;
		case (paddr_in)
		`CTS_REG_CTRL: next_rdata = {31'h0, run_enable};
		`CTS_REG_MODE: next_rdata = {30'h0, chop_mode};
		`CTS_REG_WAIT: next_rdata = {16'h0, resume_wait_frames};
		`CTS_REG_SETTLE: next_rdata = settle_cycles;
		`CTS_REG_MOFF: next_rdata = mirror_off;
		`CTS_REG_COFF: next_rdata = centroid_off;
		`CTS_REG_SPEED: next_rdata = {16'h0, shaper_speed};
		// phase readback
		// Busy covers send, move and frozen phases
		`CTS_REG_STATUS: next_rdata = {23'h0, state != CTS_IDLE &&
			state != CTS_AWAY, 3'h0, state};
		default: begin
			next_rdata = 32'h0;
			addr_ok = 1'b0;
		end
		endcase
	end

	// Zero-wait APB: ready in the access cycle after every setup
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= psel_in & ~penable_in;
		end
	end

	// Unmapped addresses answer with an error, not a hang
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pslverr_out <= 1'b0;
		end else begin
			pslverr_out <= psel_in & ~penable_in & ~addr_ok;
		end
	end

	// Read data captured in setup so it stands in the access cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h0;
		end else if (rd_en) begin
			prdata_out <= next_rdata;
		end
	end

	// Writes land only at the completing access edge
	assign wr_hit = wr_en & pready_out;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_enable <= 1'b0;
		end else if (wr_hit && paddr_in == `CTS_REG_CTRL) begin
			run_enable <= pwdata_in[`CTS_CTRL_RUN_BIT];
		end
	end

	// mode codes; 3 is not a mode and is dropped
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chop_mode <= `CTS_MODE_RESET;
		end else if (wr_hit && paddr_in == `CTS_REG_MODE &&
			pwdata_in[1:0] != 2'h3) begin
			chop_mode <= pwdata_in[1:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resume_wait_frames <= `CTS_WAIT_RESET;
		end else if (wr_hit && paddr_in == `CTS_REG_WAIT) begin
			resume_wait_frames <= pwdata_in[15:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cycles <= `CTS_SETTLE_RESET;
		end else if (wr_hit && paddr_in == `CTS_REG_SETTLE) begin
			settle_cycles <= pwdata_in;
		end
	end

	// mirror offset for the away move
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mirror_off <= 32'h0;
		end else if (wr_hit && paddr_in == `CTS_REG_MOFF) begin
			mirror_off <= pwdata_in;
		end
	end

	// centroid offset for the away move
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			centroid_off <= 32'h0;
		end else if (wr_hit && paddr_in == `CTS_REG_COFF) begin
			centroid_off <= pwdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shaper_speed <= 16'h0;
		end else if (wr_hit && paddr_in == `CTS_REG_SPEED) begin
			shaper_speed <= pwdata_in[15:0];
		end
	end

	// Zero interval settles after one moving cycle
	assign settled = (settle_cnt == 32'h0);

	// Transition sequencer
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= CTS_IDLE;
		end else begin
			case (state)
			CTS_IDLE: begin
				if (run_enable) begin
					state <= CTS_SEND;
				end
			end
			CTS_AWAY: begin
				if (!run_enable) begin
					state <= CTS_SEND;
				end
			end
			CTS_SEND: begin
				state <= CTS_MOVING;
			end
			CTS_MOVING: begin
				if (settled) begin
					state <= CTS_FROZEN;
				end
			end
			CTS_FROZEN: begin
				if (frame_cnt == 16'h0) begin
					state <= target_away ? CTS_AWAY : CTS_IDLE;
				end
			end
			default: begin
				state <= CTS_IDLE;
			end
			endcase
		end
	end

	// Direction fixed at launch; run changes mid-move wait
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_away <= 1'b0;
		end else if (state == CTS_IDLE && run_enable) begin
			target_away <= 1'b1;
		end else if (state == CTS_AWAY && !run_enable) begin
			target_away <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt <= 32'h0;
		end else if (state == CTS_SEND) begin
			settle_cnt <= settle_cycles;
		end else if (state == CTS_MOVING && !settled) begin
			settle_cnt <= settle_cnt - 32'h1;
		end
	end

	// Frames counted only once settled; earlier ticks ignored
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_cnt <= 16'h0;
		end else if (state == CTS_SEND) begin
			frame_cnt <= resume_wait_frames;
		end else if (state == CTS_FROZEN && frame_cnt != 16'h0 &&
			frame_pulse) begin
			frame_cnt <= frame_cnt - 16'h1;
		end
	end

	// Drive board valid, one pulse per move
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_msg_valid_out <= 1'b0;
		end else begin
			drive_msg_valid_out <= (state == CTS_SEND);
		end
	end

	// Message held until the next move
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_msg_out <= '0;
		end else if (state == CTS_SEND) begin
			// away or return message with speed; offsets are zero on the return
			// away move carries both chop offsets
			// same slow shaper for the return
			drive_msg_out.away <= target_away;
			drive_msg_out.mirror_offset <=
				target_away ? mirror_off : 32'h0;
			drive_msg_out.centroid_offset <=
				target_away ? centroid_off : 32'h0;
			drive_msg_out.shaper_speed <= shaper_speed;
		end
	end

	// Real-time flags toward the slope unit
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rt_flags_out <= '0;
		end else begin
			// freeze during each move and frame wait
			rt_flags_out.tt_freeze <= (state == CTS_SEND) ||
				(state == CTS_MOVING) || (state == CTS_FROZEN);
			rt_flags_out.tt_unfreeze <= (state == CTS_FROZEN) &&
				(frame_cnt == 16'h0);
			rt_flags_out.dm_loop_enable <= 1'b1;
		end
	end

	// mode copy toward the slope unit
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chop_mode_out <= `CTS_MODE_SINGLE;
		end else begin
			chop_mode_out <= chop_mode;
		end
	end
endmodule // cts_sequencer
`default_nettype wire

// *** verification/cts_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module cts_far_end
	import cts_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire cts_drive_msg_type msg_in,
	input wire logic msg_valid_in,
	input wire cts_rt_flags_type flags_in,
	output logic frame_tick_out,
	output logic [31:0] mirror_pos_out,
	output logic slow_out
);
	logic [3:0] div;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div <= 4'h0;
			frame_tick_out <= 1'b0;
			mirror_pos_out <= 32'h0;
			slow_out <= 1'b0;
		end else begin
			div <= div + 4'h1;
			frame_tick_out <= (div[3:1] == 3'h7);
			if (msg_valid_in)
				mirror_pos_out <= msg_in.away ? msg_in.mirror_offset : 32'h0;
			slow_out <= msg_valid_in | (slow_out & flags_in.tt_freeze);
		end
	end
endmodule // cts_far_end
`default_nettype wire

// *** verification/cts_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cts_props
	import cts_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pslverr_out,
	input wire logic pready_out,
	input wire cts_drive_msg_type drive_msg_out,
	input wire logic drive_msg_valid_out,
	input wire cts_rt_flags_type rt_flags_out,
	input wire logic [1:0] chop_mode_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire frz = rt_flags_out.tt_freeze;
	wire unf = rt_flags_out.tt_unfreeze;
	dm_loop_on_a: assert property ($past(rst_n_in) |->
		rt_flags_out.dm_loop_enable) else $error("dm loop off");
	msg_freeze_a: assert property (drive_msg_valid_out |->
		$rose(frz)) else $error("move without freeze");
	one_move_a: assert property (drive_msg_valid_out |=>
		(!drive_msg_valid_out)[*8]) else $error("moves too close");
	settle_hold_a: assert property ($rose(frz) |=> frz[*8])
		else $error("freeze cut short");
	unfrz_cause_a: assert property (unf |-> $past(frz))
		else $error("unfreeze without freeze");
	unfrz_ends_a: assert property (unf |=> !frz && !unf)
		else $error("freeze stays after release");
	mode_legal_a: assert property (chop_mode_out != 2'h3)
		else $error("illegal chop mode");
	apb_nowait_a: assert property (psel_in && penable_in |-> pready_out)
		else $error("access not answered");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	cover property (drive_msg_valid_out && drive_msg_out.away);
	cover property (drive_msg_valid_out && !drive_msg_out.away);
	cover property (unf);
	cover property (pslverr_out);
endmodule // cts_props
bind cts_sequencer cts_props #(.ADDR_W(ADDR_W)) props_i (
	.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pslverr_out(pslverr_out),
	.pready_out(pready_out),
	.drive_msg_out(drive_msg_out),
	.drive_msg_valid_out(drive_msg_valid_out),
	.rt_flags_out(rt_flags_out),
	.chop_mode_out(chop_mode_out)
);
`default_nettype wire

// *** verification/testbench.sv ***
`include "cts_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cts_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
	logic [11:0] pa = 12'h0;
	logic [31:0] pwd = 32'h0, r, moff, coff, w;
	logic [15:0] spd;
	wire logic [31:0] prd, mpos;
	wire logic prdy, perr, tick, dval, slow;
	wire logic [1:0] mode;
	wire cts_drive_msg_type dmsg;
	wire cts_rt_flags_type fl;
	int bad_count = 0, n_compared = 0;
	always #5 clk = ~clk;
	cts_sequencer #(.ADDR_W(12)) uut (.sys_clk_in(clk), .rst_n_in(rst_n),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .frame_tick_in(tick), .drive_msg_out(dmsg),
		.drive_msg_valid_out(dval), .rt_flags_out(fl), .chop_mode_out(mode));
	cts_far_end far (.sys_clk_in(clk), .rst_n_in(rst_n), .msg_in(dmsg),
		.msg_valid_in(dval), .flags_in(fl), .frame_tick_out(tick),
		.mirror_pos_out(mpos), .slow_out(slow));
	task finish_test;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1;
		pwr <= wr;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (prdy === 1'b1) break;
		end
		r = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
		if (i == 20) begin
			chk(0, "apb hang");
			finish_test;
		end
	endtask
	task move(input logic away);
		int i, tk;
		logic lt;
		apb(1, `CTS_REG_CTRL, {31'h0, away});
		for (i = 0; i < 50 && dval !== 1'b1; i++) @(posedge clk);
		chk(dval === 1 && dmsg.away === away, "no move message");
		if (dval !== 1'b1) finish_test;
		chk(dmsg.shaper_speed === spd, "shaper speed");
		chk(!away || (dmsg.mirror_offset === moff && dmsg.centroid_offset === coff), "offsets");
		chk(fl.tt_freeze === 1 && fl.dm_loop_enable === 1, "freeze");
		apb(0, `CTS_REG_STATUS, 0);
		chk(r[8] === 1'b1, "busy bit");
		chk(slow === 1'b1, "slow shaper");
		tk = 0;
		lt = tick;
		for (i = 0; i < 2000 && fl.tt_unfreeze !== 1'b1; i++) begin
			@(posedge clk);
			tk += int'(tick && !lt);
			lt = tick;
		end
		chk(i < 2000 && tk >= w && tk <= w + 2, "frame wait");
		if (i == 2000) finish_test;
		chk(mpos === (away ? moff : 32'h0), "mirror position");
		repeat (2) @(posedge clk);
		apb(0, `CTS_REG_STATUS, 0);
		chk(r[4:0] === (away ? 5'h08 : 5'h01) && r[8] === 0, "state");
		chk(slow === 1'b0, "shaper restored");
		$display("move %0d done", away);
	endtask
	initial begin
		void'($urandom(42));
		repeat (8) @(posedge clk);
		rst_n <= 1;
		apb(0, `CTS_REG_WAIT, 0);
		chk(r === 32'h2, "wait reset");
		apb(0, `CTS_REG_SETTLE, 0);
		chk(r === 32'h000f4240, "settle reset");
		apb(0, 12'h020, 0);
		chk(e === 1 && r === 32'h0, "unmapped");
		for (int m = 0; m < 4; m++) begin
			apb(1, `CTS_REG_MODE, m);
			repeat (2) @(posedge clk);
			chk(mode === (m == 3 ? 2'h2 : m[1:0]), "mode");
		end
		$display("register tests done");
		apb(1, `CTS_REG_SETTLE, 32'ha);
		repeat (3) begin
			w = $urandom_range(3, 1);
			moff = $urandom;
			coff = $urandom;
			apb(1, `CTS_REG_WAIT, w);
			apb(1, `CTS_REG_MOFF, moff);
			apb(1, `CTS_REG_COFF, coff);
			spd = 16'($urandom_range(65535, 1));
			apb(1, `CTS_REG_SPEED, {16'h0, spd});
			move(1);
			move(0);
		end
		apb(1, `CTS_REG_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		rst_n <= 0;
		repeat (2) @(posedge clk);
		chk(fl === 3'h0 && dval === 1'b0 && mode === 2'h0, "reset out");
		rst_n <= 1;
		apb(0, `CTS_REG_STATUS, 0);
		chk(r[8:0] === 9'h001, "reset state");
		apb(0, `CTS_REG_MOFF, 0);
		chk(r === 32'h0, "reset offset");
		$display("reset test done");
		finish_test;
	end
endmodule // testbench
`default_nettype wire
